/* etc_defs.vh */
`ifndef ETC_DEFS_VH
`define ETC_DEFS_VH
// Clock select codes
`define ETC_CKS_STOP 2'h0
`define ETC_CKS_INT1 2'h1
`define ETC_CKS_INT2 2'h2
`define ETC_CKS_EXT 2'h3
// Output action codes for compare-match
`define ETC_OUT_NONE 2'h0
`define ETC_OUT_LOW 2'h1
`define ETC_OUT_HIGH 2'h2
`define ETC_OUT_TOGGLE 2'h3
// Reset values
`define ETC_CNT_RST 8'h00
`define ETC_TCR_RST 8'hFF
`define ETC_OUT_RST 1'b0
`endif

/* etc_timer.v */
`timescale 1ns/1ps
// Notes on behaviour
// R1: Clear beats counter write in write state.
// R2: Counter write beats increment; increment lost.
// R3: Constant write suppresses coincident compare-match.
// R4: Capture into C suppresses match C.
// R5: Simultaneous matches: toggle, high, low, none.
// R6: Count on falling edge of selected clock.
// R7: Select rewrite high-to-low counts once.
// R8: High clock to stop counts once.
// R9: Internal/external switch may also count spuriously.
// R10: Cascade plus match-count stops both counters.
// R11: Software must not set both cascade modes.
// R12: Match when counter equals constant register.
module etc_timer (
  input wire sys_clk,
  input wire rst_b,
  input wire clk_int1,
  input wire clk_int2,
  input wire clk_ext,
  input wire clock_select_lo,
  input wire clock_select_hi,
  input wire cnt_clear,
  input wire cnt_wr,
  input wire [7:0] cnt_wr_data,
  input wire time_constant_reg_a_wr,
  input wire time_constant_reg_b_wr,
  input wire time_constant_reg_c_wr,
  input wire [7:0] time_constant_reg_wr_data,
  input wire capture_strobe,
  input wire [1:0] out_act_a,
  input wire [1:0] out_act_b,
  input wire cascade_16bit,
  input wire match_count_mode,
  input wire pair_clock_pulse,
  output reg [7:0] timer_count_value,
  output reg [7:0] time_constant_reg_a,
  output reg [7:0] time_constant_reg_b,
  output reg [7:0] time_constant_reg_c,
  output reg [7:0] capture_input_reg,
  output reg match_a,
  output reg match_b,
  output reg match_c,
  output reg timer_out,
  output reg count_pulse
);

`include "etc_defs.vh"

// ==========================================================
// Clock selection and falling-edge detection
// ==========================================================
reg sel_clk;
reg sel_clk_prev;
wire [1:0] cks;
wire fall_edge;
wire next_count_en;

assign cks = {clock_select_hi, clock_select_lo};

// Stop reads as low, so a high source switched to stop looks like a fall
always @* begin
  case (cks)
    `ETC_CKS_INT1: sel_clk = clk_int1;
    `ETC_CKS_INT2: sel_clk = clk_int2;
    `ETC_CKS_EXT: sel_clk = clk_ext;
    default: sel_clk = 1'b0;
  endcase
end

// R6: falling edge detect
// Edge is taken on the muxed level, so a select change that drops the
// level is counted just like a real edge; this copies the original quirk.
always @(posedge sys_clk) begin
  if (!rst_b) begin
    sel_clk_prev <= 1'b0;
  end else begin
    sel_clk_prev <= sel_clk;
  end
end

// R7: rewrite drop counts
// R8: high to stop counts
// R9: int/ext swap counts
assign fall_edge = sel_clk_prev & ~sel_clk;

// R10: cascade lockout
// R11: both modes set is a software fault; counters simply halt
// In cascade the pair's carry pulse replaces the local edge detector
assign next_count_en = (cascade_16bit & match_count_mode) ? 1'b0 :
                       (cascade_16bit ? pair_clock_pulse : fall_edge);

always @(posedge sys_clk) begin
  if (!rst_b) begin
    count_pulse <= 1'b0;
  end else begin
    count_pulse <= next_count_en;
  end
end

// ==========================================================
// Counter
// ==========================================================
// Wraps from FF to 00; overflow flagging lives outside this block
always @(posedge sys_clk) begin
  if (!rst_b) begin
    timer_count_value <= `ETC_CNT_RST;
  end else if (cnt_clear) begin
    // R1: clear wins write
    timer_count_value <= `ETC_CNT_RST;
  end else if (cnt_wr) begin
    // R2: write wins increment
    timer_count_value <= cnt_wr_data;
  end else if (next_count_en) begin
    timer_count_value <= timer_count_value + 8'h01;
  end
end

// ==========================================================
// Constant registers, capture and compare
// ==========================================================
always @(posedge sys_clk) begin
  if (!rst_b) begin
    // Constants start at FF so a cleared counter does not match at once
    time_constant_reg_a <= `ETC_TCR_RST;
    time_constant_reg_b <= `ETC_TCR_RST;
    time_constant_reg_c <= `ETC_TCR_RST;
    capture_input_reg <= `ETC_CNT_RST;
  end else begin
    if (time_constant_reg_a_wr) begin
      time_constant_reg_a <= time_constant_reg_wr_data;
    end
    if (time_constant_reg_b_wr) begin
      time_constant_reg_b <= time_constant_reg_wr_data;
    end
    if (time_constant_reg_c_wr) begin
      time_constant_reg_c <= time_constant_reg_wr_data;
    end
    if (capture_strobe) begin
      // Capture takes the count as it stood before this edge
      capture_input_reg <= timer_count_value;
    end
  end
end

// ==========================================================
// Compare entries A, B and C
// ==========================================================
wire [23:0] tcr_all;
wire [2:0] tcr_wr_all;
wire [2:0] hold_off;
wire [2:0] eq_all;
wire [2:0] next_match;
wire next_match_a;
wire next_match_b;
wire next_match_c;

assign tcr_all = {time_constant_reg_c, time_constant_reg_b, time_constant_reg_a};
assign tcr_wr_all = {time_constant_reg_c_wr, time_constant_reg_b_wr, time_constant_reg_a_wr};

// R4: capture suppresses match C
// Only entry C is held off by capture_strobe; its compare uses time_constant_reg_c, not the capture register
assign hold_off = {capture_strobe, 2'h0};

genvar idx;
generate
  for (idx = 0; idx < 3; idx = idx + 1) begin : g_cmp
    // R12: equality compare
    assign eq_all[idx] = (timer_count_value == tcr_all[8*idx +: 8]);
    // R3: write suppresses match
    assign next_match[idx] = eq_all[idx] & ~tcr_wr_all[idx] & ~hold_off[idx];
  end
endgenerate

assign next_match_a = next_match[0];
assign next_match_b = next_match[1];
assign next_match_c = next_match[2];

// Matches are registered so each fires once per equal cycle seen
always @(posedge sys_clk) begin
  if (!rst_b) begin
    match_a <= 1'b0;
    match_b <= 1'b0;
    match_c <= 1'b0;
  end else begin
    match_a <= next_match_a;
    match_b <= next_match_b;
    match_c <= next_match_c;
  end
end

// ==========================================================
// Output pin
// ==========================================================
reg [1:0] act;

// R5: output priority
// Codes are ordered by priority, so the larger code wins on a tie
always @* begin
  act = `ETC_OUT_NONE;
  if (next_match_a && next_match_b) begin
    act = (out_act_a > out_act_b) ? out_act_a : out_act_b;
  end else if (next_match_a) begin
    act = out_act_a;
  end else if (next_match_b) begin
    act = out_act_b;
  end
end

// Pin keeps its level between matches; toggle reads it back
always @(posedge sys_clk) begin
  if (!rst_b) begin
    timer_out <= `ETC_OUT_RST;
  end else begin
    case (act)
      `ETC_OUT_TOGGLE: timer_out <= ~timer_out;
      `ETC_OUT_HIGH: timer_out <= 1'b1;
      `ETC_OUT_LOW: timer_out <= 1'b0;
      default: timer_out <= timer_out;
    endcase
  end
end

endmodule

/* etc_timer_props.sv */
`timescale 1ns/1ps
// =====
// Conflict checks
module etc_timer_props(
  input wire sys_clk, input wire rst_b, input wire cnt_clear, input wire cnt_wr,
  input wire [7:0] cnt_wr_data, input wire time_constant_reg_a_wr, input wire capture_strobe,
  input wire cascade_16bit, input wire match_count_mode, input wire match_a,
  input wire [7:0] timer_count_value, input wire [7:0] time_constant_reg_a,
  input wire match_c, input wire count_pulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_eq;
    timer_count_value==time_constant_reg_a && !time_constant_reg_a_wr;
  endsequence
  AST_CLR: assert property (cnt_clear |=> timer_count_value==8'h00)
    else $error("clear lost");
  AST_WR: assert property (cnt_wr && !cnt_clear |=> timer_count_value==$past(cnt_wr_data))
    else $error("write lost");
  AST_TWR: assert property (time_constant_reg_a_wr |=> !match_a)
    else $error("match a not held off");
  AST_CAP: assert property (capture_strobe |=> !match_c)
    else $error("match c not held off");
  AST_EQ: assert property (s_eq |=> match_a)
    else $error("match missing");
  AST_INC: assert property (count_pulse && !$past(cnt_wr || cnt_clear)
    |-> timer_count_value==$past(timer_count_value)+8'h01) else $error("bad step");
  AST_CST: assert property (cascade_16bit && match_count_mode |=> !count_pulse)
    else $error("pulse in cascade");
  AST_HLD: assert property (cascade_16bit && match_count_mode && !cnt_wr && !cnt_clear
    |=> $stable(timer_count_value)) else $error("count in cascade");
endmodule
bind etc_timer etc_timer_props i_etc_timer_props(
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .cnt_clear(cnt_clear),
  .cnt_wr(cnt_wr),
  .cnt_wr_data(cnt_wr_data),
  .time_constant_reg_a_wr(time_constant_reg_a_wr),
  .capture_strobe(capture_strobe),
  .cascade_16bit(cascade_16bit),
  .match_count_mode(match_count_mode),
  .match_a(match_a),
  .timer_count_value(timer_count_value),
  .time_constant_reg_a(time_constant_reg_a),
  .match_c(match_c),
  .count_pulse(count_pulse)
);

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic sys_clk=0, rst_b=0, clk_int1=0, clk_int2=0, clk_ext=0, cnt_clear=0, cnt_wr=0;
  logic clock_select_lo=0, clock_select_hi=0, time_constant_reg_a_wr=0, time_constant_reg_b_wr=0, time_constant_reg_c_wr=0;
  logic capture_strobe=0, cascade_16bit=0, match_count_mode=0, pair_clock_pulse=0;
  logic [7:0] cnt_wr_data=0, time_constant_reg_wr_data=0;
  logic [1:0] out_act_a=0, out_act_b=0;
  wire [7:0] timer_count_value, time_constant_reg_a, time_constant_reg_b;
  wire [7:0] time_constant_reg_c, capture_input_reg;
  wire match_a, match_b, match_c, timer_out, count_pulse;
  int bad_count=0, num_checks=0, cyc=0;
  etc_timer i_etc_timer(
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_int1(clk_int1),
    .clk_int2(clk_int2),
    .clk_ext(clk_ext),
    .clock_select_lo(clock_select_lo),
    .clock_select_hi(clock_select_hi),
    .cnt_clear(cnt_clear),
    .cnt_wr(cnt_wr),
    .cnt_wr_data(cnt_wr_data),
    .time_constant_reg_a_wr(time_constant_reg_a_wr),
    .time_constant_reg_b_wr(time_constant_reg_b_wr),
    .time_constant_reg_c_wr(time_constant_reg_c_wr),
    .time_constant_reg_wr_data(time_constant_reg_wr_data),
    .capture_strobe(capture_strobe),
    .out_act_a(out_act_a),
    .out_act_b(out_act_b),
    .cascade_16bit(cascade_16bit),
    .match_count_mode(match_count_mode),
    .pair_clock_pulse(pair_clock_pulse),
    .timer_count_value(timer_count_value),
    .time_constant_reg_a(time_constant_reg_a),
    .time_constant_reg_b(time_constant_reg_b),
    .time_constant_reg_c(time_constant_reg_c),
    .capture_input_reg(capture_input_reg),
    .match_a(match_a),
    .match_b(match_b),
    .match_c(match_c),
    .timer_out(timer_out),
    .count_pulse(count_pulse)
  );
  always #50 sys_clk=~sys_clk;
  // =====
  // Helpers
  task automatic st(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    num_checks++;
    if (s!==e) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d checks %0d", bad_count, num_checks);
    if (bad_count==0 && num_checks>0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 900) begin
      bad_count++;
      end_sim();
    end
  end
  // =====
  // Scenarios
  task automatic t_wr;
    cnt_wr_data=8'h5A;
    {cnt_wr, cnt_clear}=2'h3;
    st(1);
    {cnt_wr, cnt_clear}=2'h0;
    chk("clr", timer_count_value, 8'h00);
    {clk_int1, clock_select_lo}=2'h3;
    st(2);
    {clk_int1, cnt_wr}=2'h1;
    st(1);
    cnt_wr=0;
    st(2);
    chk("wr", timer_count_value, 8'h5A);
  endtask
  task automatic t_edge;
    clk_int1=1;
    st(2);
    clk_int1=0;
    st(3);
    chk("fall", timer_count_value, 8'h5B);
    clk_int1=1;
    st(2);
    clock_select_lo=0;
    st(3);
    chk("stop", timer_count_value, 8'h5C);
    clock_select_lo=1;
    st(2);
    clock_select_hi=1;
    st(3);
    chk("ext", timer_count_value, 8'h5D);
  endtask
  // Cascade stays on afterwards so the compare test sees a frozen counter
  task automatic t_cas;
    {cascade_16bit, match_count_mode, pair_clock_pulse, clk_ext}=4'hF;
    st(1);
    {pair_clock_pulse, clk_ext}=2'h0;
    st(3);
    chk("cas", timer_count_value, 8'h5D);
  endtask
  task automatic t_cmp;
    time_constant_reg_wr_data=8'h5D;
    {time_constant_reg_a_wr, time_constant_reg_b_wr, time_constant_reg_c_wr, out_act_a, out_act_b}=7'h76;
    st(1);
    {time_constant_reg_a_wr, time_constant_reg_b_wr, time_constant_reg_c_wr}=3'h0;
    st(2);
    chk("eq", match_a, 8'h01);
    chk("pin", timer_out, 8'h01);
    chk("tcb", time_constant_reg_b, 8'h5D);
    chk("tcc", time_constant_reg_c, 8'h5D);
    chk("mb", match_b, 8'h01);
    {time_constant_reg_a_wr, capture_strobe}=2'h3;
    st(1);
    {time_constant_reg_a_wr, capture_strobe, out_act_b}=4'h0;
    chk("wa", match_a, 8'h00);
    chk("mc", match_c, 8'h00);
    chk("cap", capture_input_reg, 8'h5D);
    chk("tca", time_constant_reg_a, 8'h5D);
    st(2);
    chk("low", timer_out, 8'h00);
  endtask
  task automatic t_tog;
    {out_act_a, out_act_b}=4'hE;
    st(1);
    chk("tg1", timer_out, 8'h01);
    st(1);
    chk("tg0", timer_out, 8'h00);
    {out_act_a, cascade_16bit, match_count_mode}=4'h0;
    {clock_select_hi, clock_select_lo, clk_int2}=3'h5;
    st(2);
    clk_int2=0;
    st(1);
    chk("cp1", count_pulse, 8'h01);
    chk("int2", timer_count_value, 8'h5E);
    st(1);
    chk("cp0", count_pulse, 8'h00);
  endtask
  initial begin
    st(6);
    rst_b=1;
    t_wr();
    t_edge();
    t_cas();
    t_cmp();
    t_tog();
    end_sim();
  end
endmodule
